// [verilog/cfg_pkg.sv]
/*
 * shared constants, state encoding and helpers of the configuration mode sequencer.
 * assumes a single 250 MHz system clock.
 */
package cfg_pkg;

   // ==========================================================
   // clock and timing
   localparam int CLK_FREQ_KHZ = 250000;
   localparam int OSC_FREQ_KHZ = 4000;
   localparam int OSC_DIV_CYC = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
   localparam int OSC_CNT_W = 6;
   localparam int RECFG_LIMIT_MS = 100;
   localparam int RECFG_LIMIT_CYC = RECFG_LIMIT_MS * CLK_FREQ_KHZ;
   localparam int WDOG_W = 25;
   localparam int INIT_CNT_W = 8;
   localparam logic [INIT_CNT_W-1:0] INIT_TICKS = 8'h10;

   // ==========================================================
   // widths
   localparam int LEN_W = 24;
   localparam int DATA_W = 8;
   localparam int SCHEME_W = 3;

   // ==========================================================
   // load schemes: three active, three passive
   localparam logic [SCHEME_W-1:0] SCHEME_ACT_SERIAL = 3'h0;
   localparam logic [SCHEME_W-1:0] SCHEME_ACT_PAR_UP = 3'h1;
   localparam logic [SCHEME_W-1:0] SCHEME_ACT_PAR_DOWN = 3'h2;
   localparam logic [SCHEME_W-1:0] SCHEME_PAS_SERIAL = 3'h3;
   localparam logic [SCHEME_W-1:0] SCHEME_PAS_PAR_SYNC = 3'h4;
   localparam logic [SCHEME_W-1:0] SCHEME_PAS_PAR_ASYNC = 3'h5;
   localparam logic [LEN_W-1:0] SERIAL_STEP = 24'h000001;
   localparam logic [LEN_W-1:0] PARALLEL_STEP = 24'h000008;

   // ==========================================================
   // top-level sequence, gray along idle-load-release-init-user
   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_LOAD    = 3'h1,
      ST_RELEASE = 3'h3,
      ST_INIT    = 3'h2,
      ST_USER    = 3'h6,
      ST_ERROR   = 3'h4
   } state_e;

   // ==========================================================
   // helpers
   function automatic logic scheme_valid(input logic [SCHEME_W-1:0] s);
      scheme_valid = (s <= SCHEME_PAS_PAR_ASYNC);
   endfunction : scheme_valid

   function automatic logic is_active(input logic [SCHEME_W-1:0] s);
      is_active = (s <= SCHEME_ACT_PAR_DOWN);
   endfunction : is_active

   function automatic logic is_serial(input logic [SCHEME_W-1:0] s);
      is_serial = (s == SCHEME_ACT_SERIAL) || (s == SCHEME_PAS_SERIAL);
   endfunction : is_serial

   function automatic logic [LEN_W-1:0] bits_per_xfer(input logic [SCHEME_W-1:0] s);
      bits_per_xfer = is_serial(s) ? SERIAL_STEP : PARALLEL_STEP;
   endfunction : bits_per_xfer

endpackage : cfg_pkg

// [verilog/osc_divider.sv]
/*
 * divider giving a one-cycle enable at the internal oscillator rate.
 * assumes the system clock and a synchronous active-low reset.
 */
`timescale 1ns/100ps
module osc_divider (
   input wire logic clk_i,
   input wire logic rst_n_i,
   output logic tick_o
);
   import cfg_pkg::*;

   // ==========================================================
   // free-running count, so the rate is there in every mode
   logic [OSC_CNT_W-1:0] cnt_q;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= (cnt_q == OSC_CNT_W'(OSC_DIV_CYC - 1));
         if (cnt_q == OSC_CNT_W'(OSC_DIV_CYC - 1)) begin
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

endmodule : osc_divider

// [verilog/sram_config_mode_sequencer.sv]
/*
 * top-level command/user mode sequencer that loads configuration cells.
 * assumes all inputs synchronous to clk_i; open-drain pins resolved outside.
 */
// Functional notes
// - after every reset the cells are reloaded before any user logic runs.
// - after the load an init step clears registers, then user mode starts and enables i/o.
// - command mode spans load and init, user mode is normal operation.
// - pulling the reconfigure pin low forces command mode and a fresh load and init.
// - a reconfiguration from command mode entry to user mode finishes within 100 ms.
// - init is timed by the internal oscillator or by an external clock.
// - loading starts at power-up or when the external party releases the reconfigure pin.
// - six schemes are selectable, three device-led and three host-led.
// - device-led schemes clock the external memory from the internal oscillator.
// - the load-complete flag is held low while a 24-bit count runs to the program length.
// - a load error pulls the open-drain error flag low.
// - in device-led schemes a power failure in user or error state restarts configuration.
`timescale 1ns/100ps
module sram_config_mode_sequencer #(
   parameter int unsigned RECFG_LIMIT_CYC = cfg_pkg::RECFG_LIMIT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic reconfig_req_n_i,
   input wire logic [cfg_pkg::SCHEME_W-1:0] scheme_sel_i,
   input wire logic init_clk_sel_i,
   input wire logic ext_init_clk_i,
   input wire logic power_fail_i,
   input wire logic [cfg_pkg::LEN_W-1:0] prog_length_i,
   input wire logic [cfg_pkg::DATA_W-1:0] cfg_data_i,
   input wire logic cfg_data_valid_i,
   input wire logic cfg_error_i,
   input wire logic load_complete_flag_i,
   output logic load_complete_flag_o,
   output logic load_complete_flag_oe_n_o,
   input wire logic config_error_flag_n_i,
   output logic config_error_flag_n_o,
   output logic config_error_flag_n_oe_n_o,
   output logic cfg_clk_o,
   output logic cell_wr_en_o,
   output logic [cfg_pkg::LEN_W-1:0] cell_addr_o,
   output logic [cfg_pkg::DATA_W-1:0] cell_wr_data_o,
   output logic user_reg_clear_o,
   output logic user_logic_en_o,
   output logic user_io_en_o,
   output logic user_mode_o
);
   import cfg_pkg::*;

   // ==========================================================
   // declarations
   state_e state_q, state_d;
   logic osc_tick;
   logic ext_q;
   logic ext_rise;
   logic init_tick;
   logic [SCHEME_W-1:0] scheme_q;
   logic [LEN_W-1:0] len_q;
   logic [LEN_W-1:0] count_q;
   logic [LEN_W:0] count_next;
   logic last_xfer;
   logic take;
   logic [WDOG_W-1:0] age_q;
   logic wdog_expired;
   logic load_err;
   logic [INIT_CNT_W-1:0] init_cnt_q;
   logic start;

   // ==========================================================
   // clock sources
   osc_divider i_osc_divider (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .tick_o(osc_tick)
   );

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ext_q <= 1'b0;
      end else begin
         ext_q <= ext_init_clk_i;
      end
   end

   assign ext_rise = ext_init_clk_i & ~ext_q;
   assign init_tick = init_clk_sel_i ? ext_rise : osc_tick;

   // ==========================================================
   // load data path
   // passive: host strobe is the only pacing; active: own clock edge
   assign take = (state_q == ST_LOAD) &&
                 (is_active(scheme_q) ? (osc_tick & ~cfg_clk_o) : cfg_data_valid_i);
   assign count_next = {1'b0, count_q} + {1'b0, bits_per_xfer(scheme_q)};
   assign last_xfer = (count_next >= {1'b0, len_q});
   assign start = (state_q == ST_IDLE) && reconfig_req_n_i;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         scheme_q <= SCHEME_ACT_SERIAL;
         len_q <= '0;
      end else if (start) begin
         // captured once, so mid-load changes on the select pins do no harm
         scheme_q <= scheme_sel_i;
         len_q <= prog_length_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         count_q <= '0;
      end else if (state_q != ST_LOAD) begin
         count_q <= '0;
      end else if (take) begin
         count_q <= count_next[LEN_W-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cfg_clk_o <= 1'b0;
      end else if (state_q == ST_LOAD && is_active(scheme_q)) begin
         if (osc_tick) begin
            cfg_clk_o <= ~cfg_clk_o;
         end
      end else begin
         cfg_clk_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cell_wr_en_o <= 1'b0;
         cell_addr_o <= '0;
         cell_wr_data_o <= '0;
      end else begin
         cell_wr_en_o <= take;
         cell_addr_o <= count_q;
         cell_wr_data_o <= is_serial(scheme_q) ? {{(DATA_W-1){1'b0}}, cfg_data_i[0]} : cfg_data_i;
      end
   end

   // ==========================================================
   // reconfiguration time limit
   // a hung host or memory would otherwise leave the part dark forever
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         age_q <= '0;
      end else if (state_q == ST_LOAD || state_q == ST_RELEASE || state_q == ST_INIT) begin
         age_q <= wdog_expired ? '0 : age_q + 1'b1;
      end else begin
         age_q <= '0;
      end
   end

   assign wdog_expired = (age_q == WDOG_W'(RECFG_LIMIT_CYC - 1));
   assign load_err = cfg_error_i | ~config_error_flag_n_i | wdog_expired;

   // ==========================================================
   // init timing
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         init_cnt_q <= '0;
      end else if (state_q != ST_INIT) begin
         init_cnt_q <= '0;
      end else if (init_tick) begin
         init_cnt_q <= init_cnt_q + 1'b1;
      end
   end

   // ==========================================================
   // mode sequence
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               state_d = scheme_valid(scheme_sel_i) ? ST_LOAD : ST_ERROR;
            end
         end
         ST_LOAD: begin
            if (load_err) begin
               state_d = ST_ERROR;
            end else if (take && last_xfer) begin
               state_d = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            if (wdog_expired) begin
               state_d = ST_ERROR;
            end else if (load_complete_flag_i) begin
               state_d = ST_INIT;
            end
         end
         ST_INIT: begin
            if (wdog_expired) begin
               state_d = ST_ERROR;
            end else if (init_tick && init_cnt_q == INIT_TICKS - 1'b1) begin
               state_d = ST_USER;
            end
         end
         ST_USER: begin
            state_d = ST_USER;
         end
         ST_ERROR: begin
            state_d = ST_ERROR;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if ((state_q == ST_USER || state_q == ST_ERROR) && power_fail_i && is_active(scheme_q)) begin
         state_d = ST_IDLE;
      end
      if (!reconfig_req_n_i) begin
         state_d = ST_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // pins and user enables, registered from the next state
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         load_complete_flag_o <= 1'b0;
         load_complete_flag_oe_n_o <= 1'b0;
         config_error_flag_n_o <= 1'b0;
         config_error_flag_n_oe_n_o <= 1'b1;
         user_reg_clear_o <= 1'b0;
         user_logic_en_o <= 1'b0;
         user_io_en_o <= 1'b0;
         user_mode_o <= 1'b0;
      end else begin
         load_complete_flag_o <= 1'b0;
         load_complete_flag_oe_n_o <= (state_d == ST_RELEASE || state_d == ST_INIT ||
                                       state_d == ST_USER);
         config_error_flag_n_o <= 1'b0;
         config_error_flag_n_oe_n_o <= (state_d != ST_ERROR);
         user_reg_clear_o <= (state_d == ST_INIT);
         user_logic_en_o <= (state_d == ST_USER);
         user_io_en_o <= (state_d == ST_USER);
         user_mode_o <= (state_d == ST_USER);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   AST_RELOAD_AT_RESET: assert property ($rose(rst_n_i) |-> state_q == ST_IDLE && !user_mode_o)
      else $error("not in command mode after reset");
   AST_INIT_THEN_USER: assert property ((state_q == ST_INIT ##1 state_q == ST_USER) |->
      user_io_en_o && $past(user_reg_clear_o))
      else $error("user mode without init clear");
   AST_MODE_FLAG: assert property (user_mode_o == (state_q == ST_USER))
      else $error("user mode flag disagrees with state");
   AST_FORCED_RECONFIG: assert property (user_mode_o && !reconfig_req_n_i |=>
      !user_mode_o && state_q == ST_IDLE)
      else $error("reconfigure pin did not force command mode");
   AST_TIME_LIMIT: assert property (age_q < WDOG_W'(RECFG_LIMIT_CYC))
      else $error("reconfiguration exceeded its time limit");
   AST_WDOG_ERROR: assert property (wdog_expired && state_q != ST_IDLE &&
      reconfig_req_n_i |=> state_q == ST_ERROR) else $error("time limit not enforced");
   AST_EXT_INIT_CLK: assert property (state_q == ST_INIT && init_clk_sel_i &&
      init_cnt_q != $past(init_cnt_q) |-> $past(ext_rise))
      else $error("init advanced without external clock edge");
   AST_IDLE_HOLD: assert property (state_q == ST_IDLE && !reconfig_req_n_i |=>
      state_q == ST_IDLE)
      else $error("load began while reconfigure pin held");
   AST_BAD_SCHEME: assert property (start && scheme_sel_i > SCHEME_PAS_PAR_ASYNC |=>
      state_q == ST_ERROR)
      else $error("invalid scheme not refused");
   AST_ACTIVE_CLK: assert property ($changed(cfg_clk_o) && cfg_clk_o |->
      $past(osc_tick) && is_active(scheme_q))
      else $error("memory clock edge without oscillator tick");
   AST_LOAD_FLAG_LOW: assert property (state_q == ST_LOAD |-> !load_complete_flag_oe_n_o)
      else $error("load-complete flag released during load");
   AST_ERROR_FLAG: assert property (state_q == ST_LOAD && cfg_error_i && reconfig_req_n_i |=>
      !config_error_flag_n_oe_n_o)
      else $error("error not reported on error flag");
   AST_POWER_FAIL: assert property (user_mode_o && power_fail_i && is_active(scheme_q) |=>
      state_q == ST_IDLE)
      else $error("power failure did not restart load");
   AST_USER_IO_OFF: assert property (!user_mode_o |-> !user_io_en_o && !user_logic_en_o)
      else $error("user i/o enabled in command mode");

endmodule : sram_config_mode_sequencer

// [test/cfg_source_model.sv]
/*
 * far-side model: configuration memory plus the two pulled-up open-drain wires.
 * assumes the sequencer's memory clock and open-drain enables as inputs.
 */
`timescale 1ns/100ps
module cfg_source_model (
   input wire logic clk_i,
   input wire logic cfg_clk_i,
   input wire logic load_oe_n_i,
   input wire logic err_oe_n_i,
   input wire logic hold_load_low_i,
   input wire logic pull_err_low_i,
   output logic [cfg_pkg::DATA_W-1:0] mem_data_o,
   output logic load_wire_o,
   output logic err_wire_o
);
   import cfg_pkg::*;
   logic cfg_clk_q = 1'b0;
   logic [DATA_W-1:0] mem_q = 8'ha5;
   assign mem_data_o = mem_q;
   // ==========================================
   // memory answers each rising memory clock
   // new word only after the device sampled the old one
   always @(posedge clk_i) begin
      cfg_clk_q <= cfg_clk_i;
      if (cfg_clk_i === 1'b1 && cfg_clk_q === 1'b0) begin
         mem_q <= {mem_q[6:0], ~mem_q[7]};
      end
   end
   // ==========================================
   // open-drain wires with pull-ups
   // a host may hold the load wire low to stall init
   assign load_wire_o = (load_oe_n_i === 1'b0) ? 1'b0 : ~hold_load_low_i;
   assign err_wire_o = (err_oe_n_i === 1'b0) ? 1'b0 : ~pull_err_low_i;
endmodule : cfg_source_model

// [test/sram_config_mode_sequencer_bench.sv]
/*
 * bench of the mode sequencer: reset, errors, all schemes, power fail.
 * assumes the package and the source model are compiled first.
 */
`timescale 1ns/100ps
module sram_config_mode_sequencer_bench;
   import cfg_pkg::*;
   localparam int LIM = 4000;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic req_n = 1'b0;
   logic [2:0] scheme = 3'h3;
   logic init_sel = 1'b1;
   logic ext_clk = 1'b0;
   logic pfail = 1'b0;
   logic [23:0] plen = 24'h000002;
   logic [7:0] hdata = 8'h00;
   logic valid = 1'b0;
   logic err_in = 1'b0;
   logic hold_low = 1'b0;
   logic pull_err = 1'b0;
   logic [7:0] mdata;
   logic [7:0] wdata;
   logic [23:0] addr;
   logic lc_w, ef_w, lc_o, lc_oe_n, ef_o, ef_oe_n, dclk, wr_en, clr, ule, uio, umode;
   logic [23:0] exp_addr = 24'h0;
   logic [23:0] step = 24'h1;
   logic dclk_q = 1'b0;
   logic [7:0] mexp = 8'ha5;
   logic [2:0] ext_cnt = 3'h0;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   int wr_cnt = 0;
   int rises = 0;
   wire logic [7:0] din = (scheme < 3'h3) ? mdata : hdata;

   sram_config_mode_sequencer #(.RECFG_LIMIT_CYC(LIM)) i_sram_config_mode_sequencer (
      .clk_i(clk), .rst_n_i(rst_n), .reconfig_req_n_i(req_n), .scheme_sel_i(scheme),
      .init_clk_sel_i(init_sel), .ext_init_clk_i(ext_clk), .power_fail_i(pfail),
      .prog_length_i(plen), .cfg_data_i(din), .cfg_data_valid_i(valid),
      .cfg_error_i(err_in), .load_complete_flag_i(lc_w), .load_complete_flag_o(lc_o),
      .load_complete_flag_oe_n_o(lc_oe_n), .config_error_flag_n_i(ef_w),
      .config_error_flag_n_o(ef_o), .config_error_flag_n_oe_n_o(ef_oe_n),
      .cfg_clk_o(dclk), .cell_wr_en_o(wr_en), .cell_addr_o(addr), .cell_wr_data_o(wdata),
      .user_reg_clear_o(clr), .user_logic_en_o(ule), .user_io_en_o(uio), .user_mode_o(umode));

   cfg_source_model i_cfg_source_model (.clk_i(clk), .cfg_clk_i(dclk), .load_oe_n_i(lc_oe_n),
      .err_oe_n_i(ef_oe_n), .hold_load_low_i(hold_low), .pull_err_low_i(pull_err),
      .mem_data_o(mdata), .load_wire_o(lc_w), .err_wire_o(ef_w));

   always #2 clk = ~clk;

   // ==========================================
   // checks and closing
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done

   // ==========================================
   // monitor: write order, data, memory clock, timeout
   // external init clock has an 8-cycle period
   always @(negedge clk) begin
      cycles++;
      ext_cnt = ext_cnt + 3'h1;
      ext_clk = ext_cnt[2];
      if (dclk === 1'b1 && dclk_q === 1'b0) rises++;
      dclk_q = dclk;
      if (wr_en === 1'b1) begin
         chk(addr, exp_addr);
         if (scheme > 3'h2) chk(wdata, (8'h5a ^ exp_addr[7:0]) & (step == 1 ? 8'h01 : 8'hff));
         else begin
            // memory word as the model held it before this clock rise
            chk(wdata, mexp & (step == 1 ? 8'h01 : 8'hff));
            mexp = {mexp[6:0], ~mexp[7]};
         end
         exp_addr = exp_addr + step;
         wr_cnt++;
      end
      if (cycles == 30000) begin
         failures++;
         test_done();
      end
   end

   // ==========================================
   // sequence helpers
   function automatic logic pick(input int w);
      pick = (w == 0) ? lc_oe_n : (w == 1) ? clr : umode;
   endfunction : pick

   task automatic wait_hi(input int w, input int max, output int n);
      n = 0;
      while (pick(w) !== 1'b1 && n < max) begin
         @(negedge clk);
         n++;
      end
      chk(pick(w), 1'b1);
   endtask : wait_hi

   task automatic clear_counts();
      exp_addr = 24'h0;
      wr_cnt = 0;
      rises = 0;
      hold_low = 1'b1;
   endtask : clear_counts

   task automatic start_cfg(input logic [2:0] s, input logic [23:0] len);
      @(negedge clk);
      req_n = 1'b0;
      @(negedge clk);
      chk({umode, uio, ule, lc_oe_n}, 4'h0);
      scheme = s;
      plen = len;
      step = (s == 3'h0 || s == 3'h3) ? 24'h1 : 24'h8;
      clear_counts();
      req_n = 1'b1;
      @(negedge clk);
   endtask : start_cfg

   task automatic feed(input int n);
      for (int k = 0; k < n; k++) begin
         valid = 1'b1;
         hdata = 8'h5a ^ 8'(k * step);
         @(negedge clk);
      end
      valid = 1'b0;
   endtask : feed

   // slow host: load wire held low a while before init may start
   task automatic finish_cfg(input int n, input int per);
      int t;
      wait_hi(0, 2000, t);
      // let the monitor count the write of this same edge first
      @(negedge clk);
      chk(wr_cnt, n);
      chk(rises, scheme < 3'h3 ? n : 0);
      repeat (2) @(negedge clk);
      chk({clr, umode}, 2'h0);
      hold_low = 1'b0;
      @(negedge clk);
      chk({clr, uio, ule}, 3'h4);
      wait_hi(2, 1100, t);
      chk(t >= 15 * per - 2 && t <= 16 * per + 4, 1'b1);
      chk({clr, ule, uio}, 3'h3);
   endtask : finish_cfg

   // ==========================================
   // scenarios
   task automatic t_reset();
      repeat (16) @(negedge clk);
      chk({lc_oe_n, ef_oe_n, umode, uio, ule, wr_en, dclk, clr}, 8'h40);
      chk({lc_o, ef_o}, 2'h0);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      chk({umode, lc_oe_n, dclk}, 3'h0);
   endtask : t_reset

   // data error, low error wire, undefined scheme code
   task automatic t_error();
      for (int c = 0; c < 3; c++) begin
         start_cfg(c == 2 ? 3'h6 : 3'h3, 24'h8);
         if (c < 2) feed(2);
         err_in = (c == 0);
         pull_err = (c == 1);
         @(negedge clk);
         err_in = 1'b0;
         pull_err = 1'b0;
         @(negedge clk);
         chk({ef_oe_n, lc_oe_n, umode, ef_o, lc_o}, 5'h0);
         feed(2);
         chk(wr_cnt, c < 2 ? 2 : 0);
      end
   endtask : t_error

   // host never lets the load wire rise: the time limit must force the error state and pull the error flag low
   task automatic t_wdog();
      int n;
      start_cfg(3'h3, 24'h1);
      feed(1);
      n = 0;
      while (ef_oe_n !== 1'b0 && n < LIM + 8) begin
         @(negedge clk);
         n++;
      end
      chk(n >= LIM - 4 && n <= LIM, 1'b1);
      chk({ef_oe_n, lc_oe_n, umode, uio}, 4'h0);
   endtask : t_wdog

   // strobes stay up through active loads and must be ignored
   task automatic t_schemes();
      int t0;
      for (int s = 0; s < 6; s++) begin
         t0 = cycles;
         init_sel = (s > 2);
         start_cfg(3'(s), (s % 3 == 0) ? 24'h2 : 24'h9);
         if (s > 2) feed(2);
         else valid = 1'b1;
         finish_cfg(2, init_sel ? 8 : 62);
         valid = 1'b0;
         chk(cycles - t0 < LIM, 1'b1);
      end
   endtask : t_schemes

   task automatic t_power();
      pfail = 1'b1;
      repeat (3) @(negedge clk);
      chk(umode, 1'b1);
      pfail = 1'b0;
      init_sel = 1'b0;
      start_cfg(3'h1, 24'h9);
      finish_cfg(2, 62);
      pfail = 1'b1;
      clear_counts();
      @(negedge clk);
      pfail = 1'b0;
      repeat (2) @(negedge clk);
      chk({umode, uio, lc_oe_n}, 3'h0);
      finish_cfg(2, 62);
   endtask : t_power

   initial begin
      t_reset();
      t_error();
      t_wdog();
      t_schemes();
      t_power();
      test_done();
   end
endmodule : sram_config_mode_sequencer_bench
